/* test/dcf_pin_partner.sv */
// Producer and consumer model on the FIFO pins
`timescale 1ns/100ps
module dcf_pin_partner (
  input  wire logic       par_on_i,
  output logic            write_clock_o,
  output logic            read_clock_o,
  output logic            write_enable_n_o,
  output logic            read_enable_n_o,
  output logic [8:0]      data_o
);
  initial begin
    write_clock_o = 1'b0;
    read_clock_o = 1'b0;
    write_enable_n_o = 1'b1;
    read_enable_n_o = 1'b1;
    data_o = 9'h1a5;
  end
  // Clocks stand still between transfers, 103.3 ns period while running
  task automatic wr(input logic [8:0] d, input logic en_n);
    #23.3;
    data_o = par_on_i ? {1'b0, d[7:0]} : d;
    write_enable_n_o = en_n;
    #40 write_clock_o = 1'b1;
    #40 write_clock_o = 1'b0;
    write_enable_n_o = 1'b1;
    // Released lines must not keep the last word
    data_o = ~data_o;
  endtask : wr
  task automatic rd(input logic en_n);
    #23.3;
    read_enable_n_o = en_n;
    #40 read_clock_o = 1'b1;
    #40 read_clock_o = 1'b0;
    read_enable_n_o = 1'b1;
  endtask : rd
endmodule : dcf_pin_partner

/* test/dcf_tb_top.sv */
// Self-checking bench for the dual clock flagged FIFO
`timescale 1ns/100ps
`define CK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end
module dual_clock_fifo_with_flags_parity_tb_top;
  import dcf_pkg::*;
  localparam int D = 16;
  logic        clk, rst, oe_n, mr_n, cyc, stb, we, ack;
  logic        wclk, rclk, we_n, re_n, q_oe, hf, ef, qf, flt_n, flt, pop;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, s;
  logic [8:0]  din, q, ev;
  dcf_mode_t   mode, mode_m;
  dcf_mode_t   md [6];
  logic [8:0]  qm [$];
  int          fails, n_checks, seed, i, j;

  dcf_top #(.DEPTH(D), .WIDTH(9)) dut (
    .sys_clk_i(clk), .sys_rst_i(rst),
    .write_clock_i(wclk), .read_clock_i(rclk),
    .write_enable_n_i(we_n), .read_enable_n_i(re_n),
    .output_enable_n_i(oe_n), .master_reset_n_i(mr_n),
    .data_i(din), .q_o(q), .q_oe_o(q_oe),
    .half_full_flag_n_o(hf), .empty_or_full_flag_n_o(ef),
    .quarter_or_three_quarter_flag_n_o(qf), .fault_flag_n_o(flt_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .mode_o(mode));

  dcf_pin_partner p (
    .par_on_i(mode_m[2]), .write_clock_o(wclk), .read_clock_o(rclk),
    .write_enable_n_o(we_n), .read_enable_n_o(re_n), .data_o(din));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task tally_and_finish;
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    fails++;
    tally_and_finish;
  end

  // Wait on ack is bounded; a silent slave counts as a mismatch
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 60);
    s = rdat;
    if (ack !== 1'b1)
      fails++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  function automatic logic [8:0] ex(input logic [8:0] v);
    case (mode_m[2:1])
      2'b10: ex = {^v[7:0] ^ mode_m[0], v[7:0]};
      2'b11: ex = {1'b1, v[7:0]};
      default: ex = v;
    endcase
  endfunction : ex

  task automatic chk;
    int n;
    logic [3:0] e;
    n = qm.size();
    e = {!flt, !(n > D/2), !(n <= D/4 || n >= 3*D/4), !(n == 0 || n == D)};
    `CK("flags", e, {flt_n, hf, qf, ef})
    wb(1'b0, 8'h04, 32'h0);
    `CK("stat", {mode_m, 1'b1, e}, {s[10:8], s[4:0]})
    wb(1'b0, 8'h08, 32'h0);
    `CK("level", 32'(n), s)
    `CK("mode", mode_m, mode)
  endtask : chk

  task automatic op(input logic w, input logic en_n, input logic [8:0] d);
    pop = 1'b0;
    if (w) begin
      p.wr(d, en_n);
      if (!en_n && qm.size() < D)
        qm.push_back(d);
      else if (!en_n)
        flt = 1'b1;
    end else begin
      p.rd(en_n);
      if (!en_n && qm.size() > 0) begin
        ev = ex(qm.pop_front());
        pop = 1'b1;
      end else if (!en_n)
        flt = 1'b1;
    end
    repeat (8) @(posedge clk);
    if (pop) `CK("q", ev, q)
  endtask : op

  // Idle edges on both clocks bring every flag up to date
  task automatic refresh;
    op(1'b1, 1'b1, 9'h0);
    op(1'b0, 1'b1, 9'h0);
    if (qm.size() != 0 && qm.size() != D)
      flt = 1'b0;
    chk;
  endtask : refresh

  initial begin
    md = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    seed = 88;
    fails = 0;
    n_checks = 0;
    flt = 1'b0;
    mode_m = 3'h0;
    rst = 1'b1;
    oe_n = 1'b1;
    mr_n = 1'b1;
    {cyc, stb, we, adr, wdat} = '0;
    sel = 4'hf;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    `CK("q_oe", 1'b0, q_oe)
    oe_n <= 1'b0;
    repeat (5) @(posedge clk);
    `CK("q_oe", 1'b1, q_oe)
    chk;
    // Fill one past full, then drain one past empty
    for (i = 0; i <= D; i++) begin
      op(1'b1, 1'b0, 9'($random(seed)));
      refresh;
    end
    for (i = 0; i <= D; i++) begin
      op(1'b0, 1'b0, 9'h0);
      if (qm.size() == D/2) `CK("hf_hold", 1'b0, hf)
      refresh;
    end
    // Back-to-back writes, then mixed traffic
    for (i = 0; i < 3; i++)
      op(1'b1, 1'b0, 9'($random(seed)));
    for (i = 0; i < 40; i++) begin
      op(1'($random(seed)), 1'b0, 9'($random(seed)));
      refresh;
    end
    mr_n <= 1'b0;
    repeat (5) @(posedge clk);
    mr_n <= 1'b1;
    repeat (5) @(posedge clk);
    qm.delete();
    flt = 1'b0;
    `CK("q_mr", 9'h0, q)
    refresh;
    for (i = 0; i < 6; i++) begin
      mr_n <= 1'b0;
      repeat (4) @(posedge clk);
      p.wr({6'h0, md[i]}, 1'b0);
      repeat (4) @(posedge clk);
      mr_n <= 1'b1;
      mode_m = md[i];
      repeat (4) @(posedge clk);
      qm.delete();
      flt = 1'b0;
      for (j = 0; j < 4; j++)
        op(1'b1, 1'b0, 9'($random(seed)));
      for (j = 0; j < 4; j++)
        op(1'b0, 1'b0, 9'h0);
      refresh;
    end
    wb(1'b1, 8'h00, 32'h2);
    repeat (5) @(posedge clk);
    `CK("hold", 1'b0, q_oe)
    wb(1'b0, 8'h00, 32'h0);
    `CK("ctrl", 1'b1, s[1])
    wb(1'b1, 8'h00, 32'h0);
    repeat (5) @(posedge clk);
    `CK("q_oe", 1'b1, q_oe)
    op(1'b1, 1'b0, 9'($random(seed)));
    wb(1'b1, 8'h00, 32'h1);
    repeat (5) @(posedge clk);
    qm.delete();
    refresh;
    wb(1'b1, 8'h0c, 32'hffffffff);
    wb(1'b0, 8'h0c, 32'h0);
    `CK("unmapped", 32'h0, s)
    tally_and_finish;
  end
endmodule : dual_clock_fifo_with_flags_parity_tb_top

/* verilog/dcf_defines.svh */
// Constants for the dual clock flagged FIFO
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH

`define DCF_DEPTH       4096
`define DCF_WIDTH       9
`define DCF_LANE_W      9
`define DCF_ADR_W       8
`define DCF_CTRL_OFS    8'h00
`define DCF_STAT_OFS    8'h04
`define DCF_LEVEL_OFS   8'h08
`define DCF_CTRL_FLUSH  0
`define DCF_CTRL_HOLD   1
`define DCF_ST_EF       0
`define DCF_ST_QF       1
`define DCF_ST_HF       2
`define DCF_ST_FAULT    3
`define DCF_ST_OE       4
`define DCF_ST_MODE     8
`define DCF_MODE_RST    3'h0

`endif

/* verilog/dcf_mem.sv */
// Storage array with registered read data
`timescale 1ns/100ps
module dcf_mem #(
  parameter int W  = 9,
  parameter int AW = 12
) (
  input  wire logic          sys_clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);
  logic [W-1:0] mem_r [0:(1<<AW)-1];

  // No reset: large arrays map to block RAM
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (re_i) begin
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule : dcf_mem

/* verilog/dcf_pkg.sv */
// Types for the dual clock flagged FIFO
package dcf_pkg;
  typedef enum logic [1:0] {
    DCF_PAR_OFF = 2'b00,
    DCF_PAR_GEN = 2'b10,
    DCF_PAR_CHK = 2'b11
  } dcf_par_t;
  typedef logic [2:0] dcf_mode_t;
endpackage : dcf_pkg

/* verilog/dcf_sync.sv */
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/100ps
module dcf_sync #(
  parameter int W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meta_r <= RST;
      q_o    <= RST;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : dcf_sync

/* verilog/dcf_top.sv */
// Dual clock FIFO with level flags, fault flag and byte parity
`timescale 1ns/100ps
`include "dcf_defines.svh"
module dcf_top #(
  parameter int DEPTH = `DCF_DEPTH,
  parameter int WIDTH = `DCF_WIDTH
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    write_clock_i,
  input  wire logic                    read_clock_i,
  input  wire logic                    write_enable_n_i,
  input  wire logic                    read_enable_n_i,
  input  wire logic                    output_enable_n_i,
  input  wire logic                    master_reset_n_i,
  input  wire logic [WIDTH-1:0]        data_i,
  output logic      [WIDTH-1:0]        q_o,
  output logic                         q_oe_o,
  output logic                         half_full_flag_n_o,
  output logic                         empty_or_full_flag_n_o,
  output logic                         quarter_or_three_quarter_flag_n_o,
  output logic                         fault_flag_n_o,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [`DCF_ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  output dcf_pkg::dcf_mode_t           mode_o
);
  import dcf_pkg::*;

  localparam int AW    = $clog2(DEPTH);
  localparam int PW    = AW + 1;
  localparam int LANES = WIDTH / `DCF_LANE_W;
  localparam logic [PW-1:0] CAP   = PW'(DEPTH);
  localparam logic [PW-1:0] HALF  = PW'(DEPTH / 2);
  localparam logic [PW-1:0] QUART = PW'(DEPTH / 4);
  localparam logic [PW-1:0] TQUART = PW'((3 * DEPTH) / 4);

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i+1]);
    end
    gray2bin = b;
  endfunction : gray2bin

  // Parity bit over one lane byte; odd selects inverted sense
  function automatic logic lane_par(input logic [7:0] byte_v,
                                    input logic       odd);
    lane_par = (^byte_v) ^ odd;
  endfunction : lane_par

  // Pin synchronisers; data is delayed equally with its clock
  logic             wclk_s;
  logic             rclk_s;
  logic             we_n_s;
  logic             re_n_s;
  logic             oe_n_s;
  logic             mr_n_s;
  logic [WIDTH-1:0] d_s;

  // Reset to pin idle levels: clocks low, strobes high, no false edge
  dcf_sync #(.W(6), .RST(6'h0f)) u_ctl_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({write_clock_i, read_clock_i, write_enable_n_i,
                 read_enable_n_i, output_enable_n_i, master_reset_n_i}),
    .q_o       ({wclk_s, rclk_s, we_n_s, re_n_s, oe_n_s, mr_n_s})
  );

  dcf_sync #(.W(WIDTH)) u_dat_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (data_i),
    .q_o       (d_s)
  );

  logic wclk_d_r;
  logic rclk_d_r;
  logic wr_edge;
  logic rd_edge;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wclk_d_r <= 1'b0;
      rclk_d_r <= 1'b0;
    end else begin
      wclk_d_r <= wclk_s;
      rclk_d_r <= rclk_s;
    end
  end

  assign wr_edge = wclk_s & ~wclk_d_r;
  assign rd_edge = rclk_s & ~rclk_d_r;

  // Bus control: flush pulse and output hold
  logic flush_r;
  logic hold_r;
  logic wb_hit;
  logic fifo_clr;

  assign wb_hit   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign fifo_clr = ~mr_n_s | flush_r;

  // Pointers and gray copies
  logic [PW-1:0] wptr_r;
  logic [PW-1:0] rptr_r;
  logic [PW-1:0] wptr_g_r;
  logic [PW-1:0] rptr_g_r;
  logic [PW-1:0] wptr_gs;
  logic [PW-1:0] rptr_gs;
  logic [PW-1:0] occ_w;
  logic [PW-1:0] occ_r;
  logic          full_w;
  logic          empty_r;
  logic          wr_fire;
  logic          rd_fire;

  // Each side sees the far pointer late, so its limit is safe
  dcf_sync #(.W(2 * PW)) u_ptr_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({wptr_g_r, rptr_g_r}),
    .q_o       ({wptr_gs, rptr_gs})
  );

  assign occ_w   = wptr_r - gray2bin(rptr_gs);
  assign occ_r   = gray2bin(wptr_gs) - rptr_r;
  assign full_w  = (occ_w == CAP);
  assign empty_r = (occ_r == '0);
  assign wr_fire = wr_edge & ~we_n_s & ~full_w & ~fifo_clr;
  assign rd_fire = rd_edge & ~re_n_s & ~empty_r & ~fifo_clr;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || fifo_clr) begin
      wptr_r   <= '0;
      wptr_g_r <= '0;
    end else begin
      if (wr_fire) begin
        wptr_r <= wptr_r + PW'(1);
      end
      wptr_g_r <= bin2gray(wptr_r);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || fifo_clr) begin
      rptr_r   <= '0;
      rptr_g_r <= '0;
    end else begin
      if (rd_fire) begin
        rptr_r <= rptr_r + PW'(1);
      end
      rptr_g_r <= bin2gray(rptr_r);
    end
  end

  // Parity mode, caught on a write edge during reset
  dcf_mode_t mode_r;
  dcf_par_t  par_mode;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mode_r <= `DCF_MODE_RST;
    end else if (wr_edge && !mr_n_s && !we_n_s) begin
      mode_r <= d_s[2:0];
    end
  end

  assign par_mode = !mode_r[2] ? DCF_PAR_OFF :
                    (mode_r[1] ? DCF_PAR_CHK : DCF_PAR_GEN);

  // With parity on, lane top inputs are ignored; stored parity replaces them
  logic [WIDTH-1:0] wdata;
  always_comb begin
    wdata = d_s;
    if (par_mode != DCF_PAR_OFF) begin
      for (int l = 0; l < LANES; l++) begin
        wdata[l*9+8] = lane_par(d_s[l*9 +: 8], mode_r[0]);
      end
    end
  end

  logic [WIDTH-1:0] rdata;
  logic             rd_pend_r;

  dcf_mem #(.W(WIDTH), .AW(AW)) u_mem (
    .sys_clk_i (sys_clk_i),
    .we_i      (wr_fire),
    .waddr_i   (wptr_r[AW-1:0]),
    .wdata_i   (wdata),
    .re_i      (rd_fire),
    .raddr_i   (rptr_r[AW-1:0]),
    .rdata_o   (rdata)
  );

  // Output word with generated or checked parity
  logic [WIDTH-1:0] qword;
  always_comb begin
    qword = rdata;
    if (par_mode == DCF_PAR_CHK) begin
      for (int l = 0; l < LANES; l++) begin
        qword[l*9+8] = (lane_par(rdata[l*9 +: 8], mode_r[0]) ==
                        rdata[l*9+8]);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || fifo_clr) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= rd_fire;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || fifo_clr) begin
      q_o <= '0;
    end else if (rd_pend_r) begin
      q_o <= qword;
    end
  end

  // Output enable follows the pin three sys clocks later unless hold is set, no edge needed
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      q_oe_o <= 1'b0;
    end else begin
      q_oe_o <= ~oe_n_s & ~hold_r;
    end
  end

  // Flags: half flag moves on every write edge; for the others write edges own the upper half, read edges the lower
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || fifo_clr) begin
      half_full_flag_n_o <= 1'b1;
    end else if (wr_edge) begin
      half_full_flag_n_o <= ~(occ_w > HALF);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || fifo_clr) begin
      empty_or_full_flag_n_o            <= 1'b0;
      quarter_or_three_quarter_flag_n_o <= 1'b0;
    end else if (wr_edge && occ_w > HALF) begin
      empty_or_full_flag_n_o            <= ~full_w;
      quarter_or_three_quarter_flag_n_o <= ~(occ_w >= TQUART);
    end else if (rd_edge && occ_r <= HALF) begin
      empty_or_full_flag_n_o            <= ~empty_r;
      quarter_or_three_quarter_flag_n_o <= (occ_r > QUART);
    end
  end

  // Fault sources latch; a new attempt wins over removal
  logic efault_r;
  logic ffault_r;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || fifo_clr) begin
      efault_r <= 1'b0;
    end else if (rd_edge) begin
      if (!re_n_s && empty_r) begin
        efault_r <= 1'b1;
      end else if (!empty_r) begin
        efault_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || fifo_clr) begin
      ffault_r <= 1'b0;
    end else if (wr_edge) begin
      if (!we_n_s && full_w) begin
        ffault_r <= 1'b1;
      end else if (!full_w) begin
        ffault_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      fault_flag_n_o <= 1'b1;
    end else begin
      fault_flag_n_o <= ~(efault_r | ffault_r);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mode_o <= `DCF_MODE_RST;
    end else begin
      mode_o <= mode_r;
    end
  end

  // Wishbone slave, one wait state, unmapped reads give zero
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      flush_r <= 1'b0;
      hold_r  <= 1'b0;
    end else begin
      flush_r <= 1'b0;
      if (wb_hit && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == `DCF_CTRL_OFS) begin
        flush_r <= wb_dat_i[`DCF_CTRL_FLUSH];
        hold_r  <= wb_dat_i[`DCF_CTRL_HOLD];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_hit && !wb_we_i) begin
      wb_dat_o <= '0;
      unique case (wb_adr_i)
        `DCF_CTRL_OFS: wb_dat_o[`DCF_CTRL_HOLD] <= hold_r;
        `DCF_STAT_OFS: begin
          wb_dat_o[`DCF_ST_EF]    <= empty_or_full_flag_n_o;
          wb_dat_o[`DCF_ST_QF]    <= quarter_or_three_quarter_flag_n_o;
          wb_dat_o[`DCF_ST_HF]    <= half_full_flag_n_o;
          wb_dat_o[`DCF_ST_FAULT] <= fault_flag_n_o;
          wb_dat_o[`DCF_ST_OE]    <= q_oe_o;
          wb_dat_o[`DCF_ST_MODE +: 3] <= mode_r;
        end
        `DCF_LEVEL_OFS: wb_dat_o[PW-1:0] <= occ_w;
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  store_on_write_a: assert property (
    wr_fire |=> wptr_r == $past(wptr_r) + PW'(1))
    else $error("write not stored");
  no_write_full_a: assert property (
    wr_edge && full_w && !fifo_clr |=> $stable(wptr_r))
    else $error("write into full buffer");
  read_load_a: assert property (
    rd_fire ##1 !fifo_clr |=> q_o == $past(qword))
    else $error("read word not presented");
  oe_follow_a: assert property (
    oe_n_s |=> !q_oe_o)
    else $error("outputs driven while disabled");
  half_flag_a: assert property (
    wr_edge && !fifo_clr |=> half_full_flag_n_o == !($past(occ_w) > HALF))
    else $error("half flag wrong");
  half_write_only_a: assert property (
    !wr_edge && !fifo_clr |=> $stable(half_full_flag_n_o))
    else $error("half flag moved without write edge");
  empty_flag_a: assert property (
    rd_edge && !wr_edge && occ_r == '0 && !fifo_clr
      |=> !empty_or_full_flag_n_o)
    else $error("empty flag not low");
  fault_set_a: assert property (
    rd_edge && !re_n_s && empty_r && !fifo_clr |=> ##1 !fault_flag_n_o)
    else $error("empty fault missed");
  reset_empty_a: assert property (
    fifo_clr |=> wptr_r == '0 && rptr_r == '0 && !empty_or_full_flag_n_o)
    else $error("reset did not empty");
  mode_prog_a: assert property (
    wr_edge && !mr_n_s && !we_n_s |=> mode_r == $past(d_s[2:0]))
    else $error("mode not captured");

  fill_full_c: cover property (wr_edge && full_w);
  fault_seen_c: cover property ($fell(fault_flag_n_o));
  chk_read_c: cover property (rd_pend_r && par_mode == DCF_PAR_CHK);
  half_cross_c: cover property ($fell(half_full_flag_n_o));
endmodule : dcf_top
